// >>> memory_refresh_control.sv
// Refresh control unit: interval counter, refresh address, request toward the bus.
// Assumes a 16-bit word I/O port on ref_clk and a bus that acknowledges requests
// with a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`include "refresh_defines.svh"

module memory_refresh_control
  import refresh_pkg::*;
#(
  parameter int COUNT_W = 10
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register access port
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  // Refresh request toward the processor bus
  output logic refresh_req,
  output logic [25:0] refresh_addr,
  input wire logic refresh_ack
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [`RFS_BASE_MSB:0] base_reg;        // Region base, address bits 25..14
  logic [COUNT_W-1:0] reload_reg;           // Counter start value
  logic enable_reg;                         // Unit enable
  logic [COUNT_W-1:0] count_reg;            // Live interval count
  logic [COUNT_W-1:0] count_next;
  logic [`RFS_ROW_MSB:1] row_reg;           // Row address bits 13..1
  logic [`RFS_ROW_MSB:1] row_next;
  req_state_e state_reg;
  req_state_e state_next;
  logic [15:0] rdata_next;

  // Address decode, shared by reads and writes
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire sel_base = hit(io_addr, `RFS_BASE_OFS);
  wire sel_interval = hit(io_addr, `RFS_INTERVAL_OFS);
  wire sel_control = hit(io_addr, `RFS_CONTROL_OFS);
  wire sel_row = hit(io_addr, `RFS_ROW_OFS);
  wire wr_base = io_wr && sel_base;
  wire wr_interval = io_wr && sel_interval;
  wire wr_control = io_wr && sel_control;
  wire wr_row = io_wr && sel_row;

  // Count of one marks the end of an interval
  wire count_at_one = (count_reg == COUNT_W'(1));
  wire fire = enable_reg && count_at_one;
  wire grant = (state_reg == REQ_PENDING) && refresh_ack;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-value selection

  // Disabled: hold at the start value so enabling begins a full interval
  assign count_next = !enable_reg ? reload_reg :
                      (count_reg <= COUNT_W'(1)) ? reload_reg :
                      COUNT_W'(count_reg - COUNT_W'(1));

  // Software write wins over the post-refresh step
  assign row_next = wr_row ? io_wdata[`RFS_ROW_MSB:1] :
                    grant ? `RFS_ROW_MSB'(row_reg + 1'b1) : row_reg;

  // A new interval end while one is pending is dropped, not queued
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      REQ_IDLE: begin
        if (fire) begin
          state_next = REQ_PENDING;
        end
      end
      REQ_PENDING: begin
        if (refresh_ack) begin
          state_next = REQ_IDLE;
        end
      end
      default: begin
        state_next = REQ_IDLE;
      end
    endcase
  end

  // Read mux; reserved bits and unmapped offsets read zero, except row bit 0, which reads one
  assign rdata_next =
    sel_base ? {4'h0, base_reg} :
    sel_interval ? {6'h00, reload_reg} :
    sel_control ? {enable_reg, 5'h00, count_reg} :
    sel_row ? {2'h0, row_reg, 1'b1} :
    16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers

  // Base, reload and enable
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      base_reg <= `RFS_BASE_RST;
      reload_reg <= `RFS_INTERVAL_RST;
      enable_reg <= 1'b0;
    end else begin
      if (wr_base) begin
        base_reg <= io_wdata[`RFS_BASE_MSB:0];
      end
      if (wr_interval) begin
        reload_reg <= io_wdata[COUNT_W-1:0];
      end
      if (wr_control) begin
        enable_reg <= io_wdata[`RFS_ENABLE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter, row, request and outputs

  // Control writes never touch the count
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_reg <= `RFS_COUNT_RST;
      row_reg <= `RFS_ROW_RST;
      state_reg <= REQ_IDLE;
    end else begin
      count_reg <= count_next;
      row_reg <= row_next;
      state_reg <= state_next;
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      io_rdata <= 16'h0000;
      refresh_req <= 1'b0;
      refresh_addr <= `RFS_ADDR_RST;
    end else begin
      if (io_rd) begin
        io_rdata <= rdata_next;
      end
      refresh_req <= (state_next == REQ_PENDING);
      refresh_addr <= {base_reg, row_reg, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Checks look at most two cycles back, so they stay cheap for the tools

  // Register port
  row_readback_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_row ##1 (io_rd && sel_row && !io_wr && !grant)
    |=> io_rdata[`RFS_ROW_MSB:1] == $past(io_wdata[`RFS_ROW_MSB:1], 2))
    else $error("row address did not read back");

  row_bit_one_a: assert property (@(posedge ref_clk) disable iff (reset)
    (io_rd && sel_row) |=> io_rdata[0])
    else $error("row bit 0 read as zero");

  base_to_addr_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_base ##1 !wr_base
    |=> refresh_addr[25:14] == $past(io_wdata[`RFS_BASE_MSB:0], 2))
    else $error("refresh address upper bits not from base");

  count_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    (io_rd && sel_control) |=> io_rdata[9:0] == $past(count_reg))
    else $error("control read does not show live count");

  count_ro_a: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_control && enable_reg && count_reg > COUNT_W'(1))
    |=> count_reg == COUNT_W'($past(count_reg) - COUNT_W'(1)))
    else $error("control write disturbed count");

  // Interval counter; the request is launched from the cycle that saw the enable
  disabled_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(refresh_req) |-> $past(enable_reg))
    else $error("request raised while disabled");

  disabled_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    !enable_reg |=> count_reg == $past(reload_reg))
    else $error("disabled counter not held at start value");

  count_step_a: assert property (@(posedge ref_clk) disable iff (reset)
    (enable_reg && count_reg > COUNT_W'(1))
    |=> count_reg == COUNT_W'($past(count_reg) - COUNT_W'(1)))
    else $error("enabled counter did not step down");

  reload_start_a: assert property (@(posedge ref_clk) disable iff (reset)
    fire |=> count_reg == $past(reload_reg))
    else $error("counter did not reload");

  // Request handshake
  request_raise_a: assert property (@(posedge ref_clk) disable iff (reset)
    (fire && state_reg == REQ_IDLE) |=> refresh_req)
    else $error("interval end gave no request");

  request_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    (refresh_req && !refresh_ack) |=> refresh_req)
    else $error("request dropped before acknowledge");

  request_drop_a: assert property (@(posedge ref_clk) disable iff (reset)
    grant |=> !refresh_req)
    else $error("request stayed up after acknowledge");

  row_advance_a: assert property (@(posedge ref_clk) disable iff (reset)
    (grant && !wr_row)
    |=> row_reg == `RFS_ROW_MSB'($past(row_reg) + 1'b1))
    else $error("row did not advance after refresh");

  // Coverage of the main scenarios
  req_seen_c: cover property (@(posedge ref_clk) disable iff (reset) $rose(refresh_req));
  ack_seen_c: cover property (@(posedge ref_clk) disable iff (reset) refresh_req ##1 grant);
  busy_fire_c: cover property (@(posedge ref_clk) disable iff (reset)
    fire && state_reg == REQ_PENDING);
  disable_c: cover property (@(posedge ref_clk) disable iff (reset)
    enable_reg ##1 !enable_reg);
  row_write_c: cover property (@(posedge ref_clk) disable iff (reset)
    wr_row ##1 (io_rd && sel_row));

endmodule : memory_refresh_control

// >>> refresh_defines.svh
// Constants of the refresh control unit: I/O offsets, field positions, reset values.
// Assumes one 16-bit I/O word per register at the offsets below.
`ifndef REFRESH_DEFINES_SVH
`define REFRESH_DEFINES_SVH

// Register offsets in the I/O space
`define RFS_BASE_OFS 16'hF4A0
`define RFS_INTERVAL_OFS 16'hF4A2
`define RFS_CONTROL_OFS 16'hF4A4
`define RFS_ROW_OFS 16'hF4A6

// Field positions
`define RFS_ENABLE_BIT 15
`define RFS_BASE_MSB 11
`define RFS_ROW_MSB 13
`define RFS_COUNT_MSB 9

// Reset values
`define RFS_BASE_RST 12'h000
`define RFS_INTERVAL_RST 10'h000
`define RFS_ROW_RST 13'h0000
`define RFS_COUNT_RST 10'h000
`define RFS_ADDR_RST 26'h0000001

`endif

// >>> refresh_pkg.sv
// Types of the refresh control unit.
// Assumes refresh_defines.svh supplies the numbers.
package refresh_pkg;

  // One-hot state of the refresh request
  typedef enum logic [1:0] {
    REQ_IDLE = 2'b01,
    REQ_PENDING = 2'b10
  } req_state_e;

endpackage : refresh_pkg

// >>> refresh_mem_model.sv
// Memory side of the refresh link: acknowledges each refresh request.
// Assumes ref_clk, a level request and a one-cycle acknowledge on the same clock.
`timescale 1ns/1ps

module refresh_mem_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Refresh link
  input wire logic refresh_req,
  input wire logic [25:0] refresh_addr,
  output logic refresh_ack,
  // Address seen at the last acknowledge, for the bench to compare
  output logic [25:0] acked_addr,
  // Cycles to wait before acknowledging; large values model a slow memory
  input wire logic [7:0] ack_delay
);
  logic [7:0] wait_cnt; // Cycles waited on the current request
  logic served; // Request already acknowledged, waiting for it to drop
  wire ack_due = refresh_req && !served && (wait_cnt == ack_delay);

  ////////////////////////////////////////////////////////////////////////////
  // One pulse per request; never a second ack while the request drops
  always @(posedge ref_clk) begin
    if (reset) begin
      refresh_ack <= 1'b0;
      acked_addr <= 26'h0000000;
      wait_cnt <= 8'h00;
      served <= 1'b0;
    end else if (ack_due) begin
      refresh_ack <= 1'b1;
      acked_addr <= refresh_addr;
      served <= 1'b1;
      wait_cnt <= 8'h00;
    end else begin
      refresh_ack <= 1'b0;
      if (refresh_req && !served) begin
        wait_cnt <= wait_cnt + 8'h01;
      end else if (!refresh_req) begin
        served <= 1'b0;
      end
    end
  end
endmodule : refresh_mem_model

// >>> tb_memory_refresh_control.sv
// Testbench of the refresh control unit: register port tasks and refresh checks.
// Assumes the memory model acknowledges every request after a few cycles.
`timescale 1ns/1ps

module tb_memory_refresh_control;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [15:0] io_wdata = 16'h0000;
  logic [15:0] io_rdata;
  logic refresh_req;
  logic [25:0] refresh_addr;
  logic refresh_ack;
  logic [25:0] acked_addr;
  int mismatches = 0;
  int n_checks = 0;
  int n;

  always #50 ref_clk = ~ref_clk;

  memory_refresh_control i_memory_refresh_control (.ref_clk(ref_clk), .reset(reset),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .refresh_req(refresh_req), .refresh_addr(refresh_addr),
    .refresh_ack(refresh_ack));
  refresh_mem_model i_refresh_mem_model (.ref_clk(ref_clk), .reset(reset),
    .refresh_req(refresh_req), .refresh_addr(refresh_addr), .refresh_ack(refresh_ack),
    .acked_addr(acked_addr), .ack_delay(8'h03));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and the end of the run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // Comparison of a register word
  task automatic check_reg(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check_reg

  // Comparison of a refresh-side signal
  task automatic check_sig(input string what, input logic [25:0] exp, input logic [25:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check_sig

  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk) begin io_wr <= 1'b1; io_addr <= a; io_wdata <= d; end
    @(posedge ref_clk) io_wr <= 1'b0;
  endtask : wr

  // One-cycle read strobe, data settled after the sampling edge
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge ref_clk) begin io_rd <= 1'b1; io_addr <= a; end
    @(posedge ref_clk) io_rd <= 1'b0;
    #1 check_reg("io_rdata", exp, io_rdata);
  endtask : rd

  // Bounded wait for a level on the request line
  task automatic wait_req(input logic lvl);
    n = 0;
    while (refresh_req !== lvl && n < 50) begin @(posedge ref_clk); #1 n++; end
    // A wait that runs out counts as a mismatch here
    check_sig("refresh_req level", {25'h0, lvl}, {25'h0, refresh_req});
  endtask : wait_req

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd(16'hF4A0, 16'h0000);
    rd(16'hF4A2, 16'h0000);
    rd(16'hF4A4, 16'h0000);
    rd(16'hF4A6, 16'h0001);
    wr(16'hF4A0, 16'hFFFF);
    rd(16'hF4A0, 16'h0FFF);
    wr(16'hF4A0, 16'h0ABC);
    wr(16'hF4A6, 16'hFFFF);
    rd(16'hF4A6, 16'h3FFF);
    wr(16'hF4A6, 16'h0000);
    rd(16'hF4A6, 16'h0001);
    wr(16'hF4A2, 16'hFC05);
    rd(16'hF4A2, 16'h0005);
    wr(16'hF4A4, 16'h03FF);
    rd(16'hF4A4, 16'h0005);
    wr(16'hF4A8, 16'hFFFF);
    rd(16'hF4A8, 16'h0000);
    check_sig("req idle", 26'h0, {25'h0, refresh_req});
    wr(16'hF4A4, 16'h8000);
    // Start value 5: counts 5,4,3,2,1, request one edge later
    wait_req(1'b1);
    check_sig("interval", 26'h1, {25'h0, (n == 5)});
    check_sig("refresh_addr", {12'hABC, 13'h0000, 1'b1}, refresh_addr);
    wait_req(1'b0);
    check_sig("acked_addr", {12'hABC, 13'h0000, 1'b1}, acked_addr);
    // The interval end in the acknowledge cycle is dropped, not queued
    wait_req(1'b1);
    check_sig("dropped interval", 26'h1, {25'h0, (n == 5)});
    check_sig("refresh_addr", {12'hABC, 13'h0001, 1'b1}, refresh_addr);
    rd(16'hF4A4, 16'h8004);
    wr(16'hF4A4, 16'h0000);
    repeat (20) @(posedge ref_clk);
    check_sig("req off", 26'h0, {25'h0, refresh_req});
    rd(16'hF4A4, 16'h0005);
    rd(16'hF4A6, 16'h0005);
    finish_test();
  end

  // Watchdog against a hang
  initial begin
    #(2000 * 100);
    mismatches++;
    finish_test();
  end
endmodule : tb_memory_refresh_control
